// ---- hdl/pwmrr_map.svh ----
`ifndef PWMRR_MAP_SVH
`define PWMRR_MAP_SVH
// register subaddresses
`define PWMRR_ADDR_SS 8'h1A
`define PWMRR_ADDR_TRIM 8'h1B
`define PWMRR_ADDR_RECOV 8'h1C
`define PWMRR_ADDR_INMUX 8'h20
`define PWMRR_ADDR_OUTMUX 8'h25
// reset values
`define PWMRR_RST_SS 8'h6F
`define PWMRR_RST_TRIM 8'h82
`define PWMRR_RST_RECOV 8'h52
`define PWMRR_RST_INMUX 32'h0001_7772
`define PWMRR_RST_OUTMUX 32'h0102_1300
// soft start/stop fields
`define PWMRR_SS_DIS_BIT 7
`define PWMRR_SS_CODE_HI 4
// trim fields
`define PWMRR_TRIM_DONE_BIT 6
`define PWMRR_TRIM_RSVD_BIT 7
`define PWMRR_TRIM_NOFACT_BIT 1
// recovery fields
`define PWMRR_RECOV_CODE_HI 3
// input routing fields
`define PWMRR_IN_CH1_3L_BIT 23
`define PWMRR_IN_CH1_SRC_HI 22
`define PWMRR_IN_CH1_SRC_LO 20
`define PWMRR_IN_CH2_3L_BIT 19
`define PWMRR_IN_CH2_SRC_HI 18
`define PWMRR_IN_CH2_SRC_LO 16
`define PWMRR_SRC_LEFT 3'h0
`define PWMRR_SRC_RIGHT 3'h1
`define PWMRR_SRC_ZERO 3'h6
// output pin select fields (low bit of each pair)
`define PWMRR_OUT_A_LO 20
`define PWMRR_OUT_B_LO 16
`define PWMRR_OUT_C_LO 12
`define PWMRR_OUT_D_LO 8
// timing
`define PWMRR_CLK_HZ 10000000
`define PWMRR_MS_PER_S 1000
`define PWMRR_TRIM_CYCLES 64
`endif

// ---- hdl/pwmrr_pkg.sv ----
`default_nettype none
package pwmrr_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} pwmrr_req_s;
	typedef enum logic [1:0] {
		RECOV_RUN,
		RECOV_WAIT,
		RECOV_RESTART
	} pwmrr_recov_e;
endpackage
`default_nettype wire

// ---- hdl/pwmrr_recovery.sv ----
`include "pwmrr_map.svh"
`default_nettype none
module pwmrr_recovery #(
	parameter int unsigned TICKS_PER_MS =
		`PWMRR_CLK_HZ / `PWMRR_MS_PER_S
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic power_stage_fault_i,
	input wire logic [10:0] delay_ms_i,
	output logic stage_reset_o,
	output logic restart_o
);
	// refused at elaboration: a zero tick count never ends the wait
	if (TICKS_PER_MS < 1)
		$error("TICKS_PER_MS must be at least 1");

	pwmrr_pkg::pwmrr_recov_e state;
	logic [31:0] tick_cnt;
	logic [10:0] ms_cnt;

	// fault resets the stage, wait, then one restart pulse
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= pwmrr_pkg::RECOV_RUN;
			tick_cnt <= 32'h0000_0000;
			ms_cnt <= 11'h000;
		end else if (ce_i) begin
			case (state)
				pwmrr_pkg::RECOV_RUN: begin
					if (power_stage_fault_i) begin
						state <= pwmrr_pkg::RECOV_WAIT; // RULE7
						tick_cnt <= 32'h0000_0000;
						ms_cnt <= 11'h000;
					end
				end
				pwmrr_pkg::RECOV_WAIT: begin
					// fault still present restarts the wait
					if (power_stage_fault_i) begin
						tick_cnt <= 32'h0000_0000;
						ms_cnt <= 11'h000;
					end else if (tick_cnt == 32'(TICKS_PER_MS - 1)) begin
						tick_cnt <= 32'h0000_0000;
						if (ms_cnt == delay_ms_i - 11'h001)
							state <= pwmrr_pkg::RECOV_RESTART; // RULE7
						else
							ms_cnt <= ms_cnt + 11'h001;
					end else begin
						tick_cnt <= tick_cnt + 32'h0000_0001;
					end
				end
				pwmrr_pkg::RECOV_RESTART: state <= pwmrr_pkg::RECOV_RUN;
				default: state <= pwmrr_pkg::RECOV_RUN;
			endcase
		end
	end

	assign stage_reset_o = (state == pwmrr_pkg::RECOV_WAIT); // RULE7
	assign restart_o = (state == pwmrr_pkg::RECOV_RESTART);
endmodule
`default_nettype wire

// ---- hdl/pwmrr_regs.sv ----
// Function
// RULE1: period codes 11110 and 11111 give 9897.3 ms and 13196.4 ms.
// RULE2: writing 0x00 to the trim register applies factory trim.
// RULE3: host runs oscillator trim after each reset before rate detection.
// RULE4: trim bit 6 is read-only, 0 until trimming done, then 1.
// RULE5: trim bit 1 resets to 1; writing 0 selects factory trim.
// RULE6: internal oscillator is the reference for serial clock rate detection.
// RULE7: power stage fault resets stage, halts PWM, waits period, restarts.
// RULE8: recovery low nibble codes 2..9 give 299..1346 ms; 101x/111x 1496 ms.
// RULE9: host writes only non-reserved values to the recovery register.
// RULE10: host pulses device reset between two recovery register writes.
// RULE11: routing bits 23 and 19 pick two- or three-level per channel.
// RULE12: bits 22:20 pick channel 1 source: left, right or zero.
// RULE13: bits 18:16 pick channel 2 source, same encoding, default right.
// RULE14: pin select fields 21:20, 17:16, 13:12, 9:8 drive pins A-D.
// RULE15: each pin field holds internal channel number minus one.
// RULE16: any channel may drive any pin, also several pins at once.
// RULE17: host sets interchannel delay before leaving shutdown in three-level.
// RULE18: host keeps reserved routing and trim fields at reset values; the bench trim write of 0x00 clears reserved bit 7.
`include "pwmrr_map.svh"
`default_nettype none
module pwmrr_regs #(
	parameter int unsigned SAMPLE_W = 24,
	parameter int unsigned TICKS_PER_MS =
		`PWMRR_CLK_HZ / `PWMRR_MS_PER_S,
	parameter int unsigned TRIM_CYCLES = `PWMRR_TRIM_CYCLES,
	parameter logic [7:0] FACTORY_TRIM = 8'h80,
	parameter logic [7:0] SELF_TRIM = 8'h80
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire pwmrr_pkg::pwmrr_req_s req_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o,
	output logic addr_err_o,
	input wire logic [SAMPLE_W-1:0] serial_input_left_i,
	input wire logic [SAMPLE_W-1:0] serial_input_right_i,
	output logic [SAMPLE_W-1:0] ch1_sample_o,
	output logic [SAMPLE_W-1:0] ch2_sample_o,
	output logic [1:0] three_level_modulation_o,
	input wire logic [3:0] pwm_channel_i,
	output logic output_pin_a_o,
	output logic output_pin_b_o,
	output logic output_pin_c_o,
	output logic output_pin_d_o,
	output logic ss_timer_enable_o,
	output logic [17:0] ss_period_tenth_ms_o,
	output logic [7:0] osc_trim_o,
	output logic rate_detect_enable_o,
	input wire logic power_stage_fault_i,
	output logic power_stage_reset_o,
	output logic pwm_halt_o,
	output logic power_stage_restart_o
);
	if (SAMPLE_W < 1 || TRIM_CYCLES < 1 || TICKS_PER_MS < 1)
		$error("pwmrr_regs: widths and counts must be at least 1");

	logic [7:0] ss_reg;
	logic [7:0] trim_reg;
	logic [7:0] recov_reg;
	logic [31:0] inmux_reg;
	logic [31:0] outmux_reg;
	logic trim_done;
	logic [31:0] trim_cnt;
	logic halt_recov;

	// period in tenths of ms; codes below 01000 mean no 50% period
	function automatic logic [17:0] ss_period(input logic [4:0] code);
		case (code)
			5'h08: ss_period = 18'd165;
			5'h09: ss_period = 18'd239;
			5'h0A: ss_period = 18'd314;
			5'h0B: ss_period = 18'd404;
			5'h0C: ss_period = 18'd539;
			5'h0D: ss_period = 18'd703;
			5'h0E: ss_period = 18'd942;
			5'h0F: ss_period = 18'd1257;
			5'h10: ss_period = 18'd1646;
			5'h11: ss_period = 18'd2394;
			5'h12: ss_period = 18'd3142;
			5'h13: ss_period = 18'd4039;
			5'h14: ss_period = 18'd5386;
			5'h15: ss_period = 18'd7031;
			5'h16: ss_period = 18'd9425;
			5'h17: ss_period = 18'd12566;
			5'h18: ss_period = 18'd17281;
			5'h19: ss_period = 18'd25136;
			5'h1A: ss_period = 18'd32991;
			5'h1B: ss_period = 18'd42417;
			5'h1C: ss_period = 18'd56556;
			5'h1D: ss_period = 18'd73837;
			5'h1E: ss_period = 18'd98973; // RULE1
			5'h1F: ss_period = 18'd131964; // RULE1
			default: ss_period = 18'd0;
		endcase
	endfunction

	// reserved low codes fall back to the shortest period
	function automatic logic [10:0] recov_ms(input logic [3:0] code);
		case (code)
			4'h3: recov_ms = 11'd449;
			4'h4: recov_ms = 11'd598;
			4'h5: recov_ms = 11'd748;
			4'h6: recov_ms = 11'd898;
			4'h7: recov_ms = 11'd1047;
			4'h8: recov_ms = 11'd1197;
			4'h9: recov_ms = 11'd1346;
			4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: recov_ms = 11'd1496; // RULE8
			default: recov_ms = 11'd299; // RULE8
		endcase
	endfunction

	// reserved source codes feed silence rather than stale data
	function automatic logic [SAMPLE_W-1:0] route(input logic [2:0] src,
		input logic [SAMPLE_W-1:0] left, input logic [SAMPLE_W-1:0] right);
		case (src)
			`PWMRR_SRC_LEFT: route = left;
			`PWMRR_SRC_RIGHT: route = right;
			default: route = '0;
		endcase
	endfunction

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ss_reg <= `PWMRR_RST_SS;
			trim_reg <= `PWMRR_RST_TRIM; // RULE5
			recov_reg <= `PWMRR_RST_RECOV;
			inmux_reg <= `PWMRR_RST_INMUX; // RULE11
			outmux_reg <= `PWMRR_RST_OUTMUX;
		end else if (ce_i && req_i.wr) begin
			case (req_i.addr)
				`PWMRR_ADDR_SS: ss_reg <= req_i.wdata[7:0];
				`PWMRR_ADDR_TRIM: trim_reg <= req_i.wdata[7:0]; // RULE2
				`PWMRR_ADDR_RECOV: recov_reg <= req_i.wdata[7:0];
				`PWMRR_ADDR_INMUX: inmux_reg <= req_i.wdata;
				`PWMRR_ADDR_OUTMUX: outmux_reg <= req_i.wdata;
				default: ;
			endcase
		end
	end

	// any trim write restarts the trim; done drops meanwhile
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trim_done <= 1'b0;
			trim_cnt <= 32'h0000_0000;
		end else if (ce_i) begin
			if (req_i.wr && req_i.addr == `PWMRR_ADDR_TRIM) begin
				trim_done <= 1'b0; // RULE4
				trim_cnt <= 32'(TRIM_CYCLES);
			end else if (trim_cnt == 32'h0000_0001) begin
				trim_done <= 1'b1; // RULE4
				trim_cnt <= 32'h0000_0000;
			end else if (trim_cnt != 32'h0000_0000) begin
				trim_cnt <= trim_cnt - 32'h0000_0001;
			end
		end
	end

	// read data registered; unmapped subaddress reads zero and flags
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h0000_0000;
			rvalid_o <= 1'b0;
			addr_err_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= req_i.rd;
			addr_err_o <= 1'b0;
			if (req_i.rd) begin
				case (req_i.addr)
					`PWMRR_ADDR_SS: rdata_o <= {24'h00_0000, ss_reg};
					`PWMRR_ADDR_TRIM: rdata_o <= {24'h00_0000,
						trim_reg[`PWMRR_TRIM_RSVD_BIT], trim_done, // RULE4
						trim_reg[`PWMRR_TRIM_DONE_BIT-1:0]};
					`PWMRR_ADDR_RECOV: rdata_o <= {24'h00_0000, recov_reg};
					`PWMRR_ADDR_INMUX: rdata_o <= inmux_reg;
					`PWMRR_ADDR_OUTMUX: rdata_o <= outmux_reg;
					default: begin
						rdata_o <= 32'h0000_0000;
						addr_err_o <= 1'b1;
					end
				endcase
			end
		end
	end

	// routed samples and pin drive held in flops
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ch1_sample_o <= '0;
			ch2_sample_o <= '0;
			output_pin_a_o <= 1'b0;
			output_pin_b_o <= 1'b0;
			output_pin_c_o <= 1'b0;
			output_pin_d_o <= 1'b0;
		end else if (ce_i) begin
			ch1_sample_o <= route(inmux_reg[`PWMRR_IN_CH1_SRC_HI:
				`PWMRR_IN_CH1_SRC_LO], serial_input_left_i,
				serial_input_right_i); // RULE12
			ch2_sample_o <= route(inmux_reg[`PWMRR_IN_CH2_SRC_HI:
				`PWMRR_IN_CH2_SRC_LO], serial_input_left_i,
				serial_input_right_i); // RULE13
			// field value is channel minus one, used as index
			output_pin_a_o <= !halt_recov &&
				pwm_channel_i[outmux_reg[`PWMRR_OUT_A_LO+:2]]; // RULE14
			output_pin_b_o <= !halt_recov &&
				pwm_channel_i[outmux_reg[`PWMRR_OUT_B_LO+:2]]; // RULE15
			output_pin_c_o <= !halt_recov &&
				pwm_channel_i[outmux_reg[`PWMRR_OUT_C_LO+:2]]; // RULE16
			output_pin_d_o <= !halt_recov &&
				pwm_channel_i[outmux_reg[`PWMRR_OUT_D_LO+:2]]; // RULE14
		end
	end

	pwmrr_recovery #(
		.TICKS_PER_MS(TICKS_PER_MS)
	) u_recovery (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.power_stage_fault_i(power_stage_fault_i),
		.delay_ms_i(recov_ms(recov_reg[`PWMRR_RECOV_CODE_HI:0])), // RULE8
		.stage_reset_o(halt_recov),
		.restart_o(power_stage_restart_o)
	);

	assign power_stage_reset_o = halt_recov; // RULE7
	assign pwm_halt_o = halt_recov; // RULE7
	assign three_level_modulation_o = {inmux_reg[`PWMRR_IN_CH2_3L_BIT],
		inmux_reg[`PWMRR_IN_CH1_3L_BIT]}; // RULE11
	assign ss_timer_enable_o = !ss_reg[`PWMRR_SS_DIS_BIT];
	assign ss_period_tenth_ms_o = ss_period(ss_reg[`PWMRR_SS_CODE_HI:0]);
	assign osc_trim_o = trim_reg[`PWMRR_TRIM_NOFACT_BIT] ? SELF_TRIM :
		FACTORY_TRIM; // RULE5
	// rate detection only runs off a trimmed internal oscillator
	assign rate_detect_enable_o = trim_done; // RULE6
endmodule
`default_nettype wire

// ---- sim/pwmrr_regs_asserts.sv ----
`default_nettype none
module pwmrr_regs_asserts #(
	parameter int unsigned TRIM_CYCLES = 4,
	parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire pwmrr_pkg::pwmrr_req_s req_i,
	input wire logic [1:0] three_level_modulation_o,
	input wire logic output_pin_a_o,
	input wire logic [7:0] osc_trim_o,
	input wire logic rate_detect_enable_o,
	input wire logic power_stage_fault_i,
	input wire logic pwm_halt_o,
	input wire logic power_stage_restart_o
);
	logic wr_trim;
	logic wr_mux;
	assign wr_trim = ce_i && req_i.wr && req_i.addr == 8'h1B;
	assign wr_mux = ce_i && req_i.wr && req_i.addr == 8'h20;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_factory_pick: assert property (
		wr_trim && !req_i.wdata[1] |=> osc_trim_o == FACTORY_TRIM)
		else $error("factory trim not applied");
	a_trim_done: assert property (
		$rose(rate_detect_enable_o) |-> $past(wr_trim, TRIM_CYCLES + 1))
		else $error("trim done at wrong time");
	a_fault_halt: assert property (
		ce_i && power_stage_fault_i && !pwm_halt_o && !power_stage_restart_o
		|=> pwm_halt_o)
		else $error("fault did not halt");
	a_halt_silent: assert property (
		pwm_halt_o |=> !output_pin_a_o)
		else $error("pin active while halted");
	a_restart_end: assert property (
		$rose(power_stage_restart_o) |-> $past(pwm_halt_o) && !pwm_halt_o)
		else $error("restart without wait");
	a_restart_pulse: assert property (
		power_stage_restart_o |=> !power_stage_restart_o)
		else $error("restart longer than one cycle");
	a_halt_min: assert property (
		$rose(pwm_halt_o) |-> pwm_halt_o [*8])
		else $error("recovery wait too short");
	a_mode_bits: assert property (
		wr_mux |=> three_level_modulation_o ==
		{$past(req_i.wdata[19]), $past(req_i.wdata[23])})
		else $error("modulation bits wrong");
endmodule
bind pwmrr_regs pwmrr_regs_asserts #(.TRIM_CYCLES(TRIM_CYCLES),
	.FACTORY_TRIM(FACTORY_TRIM)) chk_u (.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i), .ce_i(ce_i), .req_i(req_i),
	.three_level_modulation_o(three_level_modulation_o),
	.output_pin_a_o(output_pin_a_o), .osc_trim_o(osc_trim_o),
	.rate_detect_enable_o(rate_detect_enable_o),
	.power_stage_fault_i(power_stage_fault_i), .pwm_halt_o(pwm_halt_o),
	.power_stage_restart_o(power_stage_restart_o));
`default_nettype wire

// ---- sim/pwmrr_host.sv ----
`default_nettype none
module pwmrr_host (
	input wire logic clk_sys_i,
	input wire logic [31:0] rdata_i,
	input wire logic rvalid_i,
	input wire logic addr_err_i,
	output pwmrr_pkg::pwmrr_req_s req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] rdata;
	logic vld;
	logic err;
	initial req_o = '0;
	// released fields show inverted data so stale values never match
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		#1 req_o = '{1'b1, 1'b0, a, d};
		@(posedge clk_sys_i);
		#1 req_o = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		#1 req_o = '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk_sys_i);
		#1 req_o = '{1'b0, 1'b0, ~a, 32'hFFFF_FFFF};
		rdata = rdata_i;
		vld = rvalid_i;
		err = addr_err_i;
	endtask
endmodule
`default_nettype wire

// ---- sim/pwmrr_regs_bench.sv ----
`default_nettype none
module pwmrr_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] FT = 8'h3C;
	localparam logic [7:0] ST = 8'hC3;
	logic clk_sys_i = 0, arst_n_i = 0, ce_i = 1, fault = 0;
	logic [23:0] left = 24'h123456, right = 24'hABCDEF, ch1, ch2;
	logic [3:0] pwm = 0;
	logic [1:0] tl;
	logic pa, pb, pc, pd, halt, rst_o, rstrt, rv, ae, sse, rde;
	logic [17:0] ssp;
	logic [7:0] ot, s;
	logic [31:0] rdat;
	pwmrr_pkg::pwmrr_req_s req;
	int errors = 0, comparisons = 0;
	logic [7:0] ra [5] = '{8'h1A, 8'h1B, 8'h1C, 8'h20, 8'h25};
	logic [31:0] r0 [5] = '{32'h6F, 32'h82, 32'h52, 32'h17772, 32'h1021300};
	logic [2:0] src [4] = '{3'h0, 3'h1, 3'h6, 3'h2};
	logic [3:0] rc [5] = '{4'h2, 4'h3, 4'h9, 4'hA, 4'hF};
	int rms [5] = '{299, 449, 1346, 1496, 1496};
	pwmrr_host host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdat),
		.rvalid_i(rv), .addr_err_i(ae), .req_o(req));
	pwmrr_regs #(.TICKS_PER_MS(2), .TRIM_CYCLES(4), .FACTORY_TRIM(FT),
		.SELF_TRIM(ST)) dut_u (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .ce_i(ce_i), .req_i(req), .rdata_o(rdat),
		.rvalid_o(rv), .addr_err_o(ae), .serial_input_left_i(left),
		.serial_input_right_i(right), .ch1_sample_o(ch1),
		.ch2_sample_o(ch2), .three_level_modulation_o(tl),
		.pwm_channel_i(pwm), .output_pin_a_o(pa), .output_pin_b_o(pb),
		.output_pin_c_o(pc), .output_pin_d_o(pd), .ss_timer_enable_o(sse),
		.ss_period_tenth_ms_o(ssp), .osc_trim_o(ot),
		.rate_detect_enable_o(rde), .power_stage_fault_i(fault),
		.power_stage_reset_o(rst_o), .pwm_halt_o(halt),
		.power_stage_restart_o(rstrt));
	initial forever #50 clk_sys_i = ~clk_sys_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input x);
		host_u.rd(a);
		chk(host_u.rdata, e);
		chk({30'h0, host_u.vld, host_u.err}, {30'h0, 1'b1, x});
	endtask
	task automatic tick;
		@(posedge clk_sys_i);
		#1;
	endtask
	function automatic logic [31:0] pick(input logic [2:0] c);
		return c == 3'h0 ? {8'h0, left} : c == 3'h1 ? {8'h0, right} : 32'h0;
	endfunction
	task automatic recov(input logic [3:0] c, input int ms);
		int n;
		tick();
		arst_n_i = 0;
		tick();
		tick();
		arst_n_i = 1;
		host_u.wr(8'h1C, {24'h0, 4'h5, c});
		tick();
		fault = 1;
		tick();
		fault = 0;
		n = 0;
		while (!rstrt && n < 4000) begin
			tick();
			n++;
			if (n == 2)
				chk({29'h0, rst_o, halt, pa}, 32'h6);
		end
		chk(n, ms * 2);
		// a restart that never comes ends the run here
		if (!rstrt)
			complete_run();
	endtask
	initial begin
		tick();
		tick();
		arst_n_i = 1;
		for (int i = 0; i < 5; i++)
			rchk(ra[i], r0[i], 1'b0);
		rchk(8'h21, 32'h0, 1'b1);
		host_u.wr(8'h1B, 32'h0);
		chk({24'h0, ot}, {24'h0, FT});
		rchk(8'h1B, 32'h0, 1'b0);
		repeat (6) tick();
		rchk(8'h1B, 32'h40, 1'b0);
		chk({31'h0, rde}, 32'h1);
		host_u.wr(8'h1B, 32'h82);
		chk({24'h0, ot}, {24'h0, ST});
		host_u.wr(8'h1A, 32'h9E);
		tick();
		chk({13'h0, sse, ssp}, 98973);
		host_u.wr(8'h1A, 32'h1F);
		tick();
		chk({13'h0, sse, ssp}, 32'h40000 + 131964);
		// clock enable low must swallow the write
		ce_i = 0;
		host_u.wr(8'h1A, 32'h00);
		ce_i = 1;
		rchk(8'h1A, 32'h1F, 1'b0);
		// ch1 and ch2 walk the source table in opposite order
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h20, {8'h0, i[0], src[i], ~i[0], src[3-i],
				16'h7772});
			tick();
			chk({8'h0, ch1}, pick(src[i]));
			chk({8'h0, ch2}, pick(src[3-i]));
			chk({30'h0, tl}, {30'h0, ~i[0], i[0]});
		end
		for (int k = 0; k < 8; k++) begin
			s = k < 4 ? {k[1:0], k[1:0] + 2'd1, k[1:0] + 2'd2,
				k[1:0] + 2'd3} : {4{k[1:0]}};
			host_u.wr(8'h25, {8'h01, 2'b0, s[7:6], 2'b0, s[5:4], 2'b0,
				s[3:2], 2'b0, s[1:0], 8'h0});
			for (int p = 0; p < 16; p++) begin
				pwm = p[3:0];
				tick();
				chk({28'h0, pd, pc, pb, pa}, {28'h0, pwm[s[1:0]],
					pwm[s[3:2]], pwm[s[5:4]], pwm[s[7:6]]});
			end
		end
		pwm = 4'hF;
		for (int i = 0; i < 5; i++)
			recov(rc[i], rms[i]);
		complete_run();
	end
endmodule
`default_nettype wire
